/* src/rad_decoder.v */
// Purpose: remote-control serial receiver; address check, data latch
// Assumes: serial_in is asynchronous; thresholds in 100 MHz cycles
// Notes:   addr_only selects the nine-digit address-only variant
//
// How it works
// - first five trinary digits of each word are the address.
// - first word stores all nine digits, data outputs untouched.
// - second word needs address match, then data compared to store.
// - equal data groups copy to output latch, held until replaced.
// - valid flag rises after second word when both words fully match.
// - valid flag drops on mismatching word or four idle data periods.
// - open data digit decodes as logic one.
// - data outputs map digits six to nine in order.
// - local address digits are trinary or binary, compared exactly.
// - address-only variant compares nine digits, no data outputs.
// - address-only valid needs two identical consecutive words.
// - pulse sampled at 1.72 encoder periods: high means wide.
// - end of transmission after 33.5 encoder periods of low input.
// - word gap detected at 0.4 of end-of-transmission interval.
// - short-short is zero, long-long is one, long-short is open.
`timescale 1ns/1ps
`include "rad_regs.vh"
module rad_decoder (
  clock,
  rst_n,
  serial_in,
  addr_only,
  local_address_digits,
  dos_cycles,
  eow_cycles,
  eot_cycles,
  decoded_data_outputs,
  valid_word_flag
);
  input  wire                       clock;
  input  wire                       rst_n;
  input  wire                       serial_in;
  input  wire                       addr_only;
  input  wire [2*`RAD_DIGITS-1:0]   local_address_digits;
  input  wire [`RAD_CNT_W-1:0]      dos_cycles;
  input  wire [`RAD_CNT_W-1:0]      eow_cycles;
  input  wire [`RAD_CNT_W-1:0]      eot_cycles;
  output wire [`RAD_DATA_BITS-1:0]  decoded_data_outputs;
  output wire                       valid_word_flag;

  localparam [2:0] ST_FIRST  = 3'b001;
  localparam [2:0] ST_SECOND = 3'b010;
  localparam [2:0] ST_HOLD   = 3'b100;

  // digit from its two pulse widths
  function [1:0] tri_of;
    input first_wide;
    input second_wide;
    begin
      if (first_wide && second_wide)
        tri_of = `RAD_TRI_ONE;
      else if (first_wide)
        tri_of = `RAD_TRI_OPEN;
      else
        tri_of = `RAD_TRI_ZERO;
    end
  endfunction

  // data bits from digits six to nine; open reads as one
  function [`RAD_DATA_BITS-1:0] data_of;
    input [2*`RAD_DIGITS-1:0] w;
    begin
      data_of = {w[17] | w[16], w[15] | w[14],
                 w[13] | w[12], w[11] | w[10]};
    end
  endfunction

  // digits compared over the first n positions
  function match_n;
    input [2*`RAD_DIGITS-1:0] a;
    input [2*`RAD_DIGITS-1:0] b;
    input [3:0]               n;
    integer i;
    begin
      match_n = 1'b1;
      for (i = 0; i < `RAD_DIGITS; i = i + 1)
        if (i < n && a[i*2 +: 2] != b[i*2 +: 2])
          match_n = 1'b0;
    end
  endfunction

  wire din;
  rad_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (serial_in),
    .q     (din)
  );

  reg                       din_d_r;
  reg [`RAD_CNT_W-1:0]      hi_cnt_r;
  reg [`RAD_CNT_W-1:0]      lo_cnt_r;
  reg                       wide_r;
  reg                       half_r;
  reg                       first_wide_r;
  reg [3:0]                 idx_r;
  reg [2*`RAD_DIGITS-1:0]   word_r;
  reg                       word_ok_r;
  reg [2:0]                 state_r;
  reg [2:0]                 state_nxt;
  reg [`RAD_DATA_BITS-1:0]  data_r;
  reg                       valid_r;

  wire       rise     = din & ~din_d_r;
  wire       fall     = ~din & din_d_r;
  wire       dos_hit  = din && hi_cnt_r == dos_cycles;
  wire       eow_hit  = !din && lo_cnt_r == eow_cycles;
  wire       eot_hit  = !din && lo_cnt_r == eot_cycles;
  wire [1:0] new_digit = tri_of(first_wide_r, wide_r);
  wire [3:0] n_addr   = addr_only ? `RAD_DIGITS : `RAD_ADDR_DIGITS;

  wire [2*`RAD_DIGITS-1:0] stored;
  wire store_wr = fall && half_r && word_ok_r;

  // word complete when gap seen after all nine digits
  wire word_done = eow_hit && idx_r == `RAD_DIGITS && word_ok_r;
  wire addr_ok   = match_n(word_r, local_address_digits, n_addr);
  wire same_word = match_n(word_r, stored, `RAD_DIGITS);

  rad_word_store u_store (
    .clock    (clock),
    .rst_n    (rst_n),
    .clear    (1'b0),
    .wr_en    (store_wr && state_r != ST_SECOND),
    .wr_idx   (idx_r),
    .wr_digit (new_digit),
    .rd_word  (stored)
  );

  // pulse and idle measurement
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      din_d_r      <= 1'b0;
      hi_cnt_r     <= {`RAD_CNT_W{1'b0}};
      lo_cnt_r     <= {`RAD_CNT_W{1'b0}};
      wide_r       <= 1'b0;
      half_r       <= 1'b0;
      first_wide_r <= 1'b0;
      idx_r        <= 4'h0;
      word_r       <= {2*`RAD_DIGITS{1'b0}};
      word_ok_r    <= 1'b1;
    end else begin
      din_d_r <= din;
      if (rise) begin
        hi_cnt_r <= {{(`RAD_CNT_W-1){1'b0}}, 1'b1};
        wide_r   <= 1'b0;
      end else if (din && hi_cnt_r != {`RAD_CNT_W{1'b1}}) begin
        hi_cnt_r <= hi_cnt_r + 1'b1;
      end
      if (dos_hit)
        wide_r <= 1'b1;
      if (din)
        lo_cnt_r <= {`RAD_CNT_W{1'b0}};
      else if (lo_cnt_r != {`RAD_CNT_W{1'b1}})
        lo_cnt_r <= lo_cnt_r + 1'b1;
      if (fall) begin
        half_r <= ~half_r;
        if (!half_r) begin
          first_wide_r <= wide_r;
        end else if (idx_r < `RAD_DIGITS) begin
          word_r[idx_r*2 +: 2] <= new_digit;
          idx_r <= idx_r + 4'h1;
        end else begin
          word_ok_r <= 1'b0;
        end
      end
      if (eow_hit) begin
        half_r    <= 1'b0;
        idx_r     <= 4'h0;
        word_ok_r <= 1'b1;
      end
    end
  end

  // word sequence
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_FIRST:  if (word_done && addr_ok) state_nxt = ST_SECOND;
      ST_SECOND: if (word_done) state_nxt = ST_FIRST;
      ST_HOLD:   if (word_done) state_nxt = ST_FIRST;
      default:   state_nxt = ST_FIRST;
    endcase
    if (eot_hit)
      state_nxt = ST_FIRST;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_FIRST;
      data_r  <= {`RAD_DATA_BITS{1'b0}};
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (word_done && state_r == ST_SECOND && addr_ok && same_word) begin
        valid_r <= 1'b1;
        if (!addr_only)
          data_r <= data_of(word_r);
      end else if (word_done && !(addr_ok && (state_r == ST_FIRST ||
                   same_word))) begin
        valid_r <= 1'b0;
      end else if (eot_hit) begin
        valid_r <= 1'b0;
      end
    end
  end

  assign decoded_data_outputs = data_r;
  assign valid_word_flag      = valid_r;
endmodule

/* src/rad_regs.vh */
// Purpose: constants for the remote address/data decoder
// Assumes: 100 MHz system clock; threshold counts are in clock cycles
// Notes:   counts are defaults; the top level makes them programmable
`ifndef RAD_REGS_VH
`define RAD_REGS_VH

`define RAD_CLK_PERIOD_NS   10
`define RAD_ENC_PERIOD_NS   5000
// decision point 1.72 encoder periods = 172/100 periods
`define RAD_DOS_NUM         172
`define RAD_DOS_DEN         100
`define RAD_DOS_CYC \
  ((`RAD_ENC_PERIOD_NS*`RAD_DOS_NUM+`RAD_DOS_DEN*`RAD_CLK_PERIOD_NS-1)/ \
   (`RAD_DOS_DEN*`RAD_CLK_PERIOD_NS))
// end of transmission 33.5 encoder periods = 335/10 periods
`define RAD_EOT_NUM         335
`define RAD_EOT_DEN         10
`define RAD_EOT_CYC \
  ((`RAD_ENC_PERIOD_NS*`RAD_EOT_NUM)/(`RAD_EOT_DEN*`RAD_CLK_PERIOD_NS))
// end of word at 0.4 of end of transmission
`define RAD_EOW_NUM         4
`define RAD_EOW_DEN         10
`define RAD_EOW_CYC  ((`RAD_EOT_CYC*`RAD_EOW_NUM)/`RAD_EOW_DEN)

`define RAD_CNT_W           16
`define RAD_DIGITS          4'h9
`define RAD_ADDR_DIGITS     4'h5
`define RAD_DATA_BITS       4
// trinary digit codes
`define RAD_TRI_ZERO        2'h0
`define RAD_TRI_ONE         2'h1
`define RAD_TRI_OPEN        2'h2

`endif

/* src/rad_sync.v */
// Purpose: two flip-flop synchroniser for the serial input
// Assumes: single clock domain after the second flop
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module rad_sync (
  clock,
  rst_n,
  d,
  q
);
  input  wire clock;
  input  wire rst_n;
  input  wire d;
  output wire q;

  reg meta_r;
  reg sync_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

/* src/rad_word_store.v */
// Purpose: holds the nine received digits of the first word
// Assumes: writes one digit per cycle, reads all digits at once
// Notes:   read data come from the store register itself
`timescale 1ns/1ps
`include "rad_regs.vh"
module rad_word_store (
  clock,
  rst_n,
  clear,
  wr_en,
  wr_idx,
  wr_digit,
  rd_word
);
  input  wire                       clock;
  input  wire                       rst_n;
  input  wire                       clear;
  input  wire                       wr_en;
  input  wire [3:0]                 wr_idx;
  input  wire [1:0]                 wr_digit;
  output wire [2*`RAD_DIGITS-1:0]   rd_word;

  reg [2*`RAD_DIGITS-1:0] mem_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_r <= {2*`RAD_DIGITS{1'b0}};
    end else if (clear) begin
      mem_r <= {2*`RAD_DIGITS{1'b0}};
    end else if (wr_en && wr_idx < `RAD_DIGITS) begin
      mem_r[wr_idx*2 +: 2] <= wr_digit;
    end
  end

  assign rd_word = mem_r;
endmodule

/* testbench/rad_decoder_chk.sv */
// Purpose: port assertions for the decoder
// Assumes: count inputs fixed during traffic
// Notes:   low_r counts idle cycles of the raw line
`timescale 1ns/1ps
module rad_decoder_chk (
  input        clock,
  input        rst_n,
  input        serial_in,
  input        addr_only,
  input [15:0] eow_cycles,
  input [15:0] eot_cycles,
  input [3:0]  decoded_data_outputs,
  input        valid_word_flag
);
  logic [15:0] low_r;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      low_r <= 16'h0000;
    else
      low_r <= serial_in ? 16'h0000 : low_r + 16'h0001;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_pair;
    $rose(valid_word_flag);
  endsequence
  sequence s_eow;
    low_r >= eow_cycles && low_r <= eow_cycles + 16'h0006;
  endsequence
  property p_rst;
    $rose(rst_n) |-> {valid_word_flag, decoded_data_outputs} == 5'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_gap; s_pair |-> s_eow; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_hold; valid_word_flag && low_r < eow_cycles |=> valid_word_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_stay; s_pair |=> valid_word_flag [*8]; endproperty
  a_stay: assert property (p_stay) else $error("stay");
  property p_eot; low_r >= eot_cycles + 16'h0006 |-> !valid_word_flag;
  endproperty
  a_eot: assert property (p_eot) else $error("eot");
  property p_fall; $fell(valid_word_flag) |-> low_r >= eow_cycles; endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_data;
    $changed(decoded_data_outputs) |-> valid_word_flag;
  endproperty
  a_data: assert property (p_data) else $error("data");
  property p_addr; addr_only |-> $stable(decoded_data_outputs); endproperty
  a_addr: assert property (p_addr) else $error("addr");
endmodule
bind rad_decoder rad_decoder_chk i_rad_decoder_chk (.clock(clock),
  .rst_n(rst_n), .serial_in(serial_in), .addr_only(addr_only),
  .eow_cycles(eow_cycles), .eot_cycles(eot_cycles),
  .decoded_data_outputs(decoded_data_outputs),
  .valid_word_flag(valid_word_flag));

/* testbench/rad_decoder_tb.sv */
// Purpose: random and corner word pairs and triples into the decoder
// Assumes: encoder period of 20 clock cycles
// Notes:   expected values come from the sent digits
`timescale 1ns/1ps
module rad_decoder_tb;
  localparam ENC = 20;
  localparam EOT = ENC * 335 / 10;
  logic clock, rst_n, send_n, addr_only, ser, busy, vld;
  logic [17:0] loc, w, x;
  logic [53:0] ws;
  logic [1:0] nw;
  logic [3:0] data, exp_d;
  int fail_count, comparisons, cyc, k;
  rad_decoder i_rad_decoder (.clock(clock), .rst_n(rst_n),
    .serial_in(ser), .addr_only(addr_only), .local_address_digits(loc),
    .dos_cycles(16'((ENC * 172 + 99) / 100)),
    .eow_cycles(16'(EOT * 4 / 10)), .eot_cycles(16'(EOT)),
    .decoded_data_outputs(data), .valid_word_flag(vld));
  rad_enc_model #(.ENC(ENC)) i_rad_enc_model (.clock(clock),
    .send_request_n(send_n), .words(ws), .n_words(nw),
    .serial_out(ser), .busy(busy));
  function automatic logic [17:0] flip(logic [17:0] v, int d);
    flip = v;
    flip[2*d +: 2] = {1'b0, v[2*d +: 2] == 2'h0};
  endfunction
  function automatic logic [3:0] dat(logic [17:0] v);
    dat = {|v[17:16], |v[15:14], |v[13:12], |v[11:10]};
  endfunction
  task automatic cmp(logic [4:0] got, logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {rst_n, addr_only, loc, ws, nw, exp_d} = '0;
    send_n = 1'b1;
    void'($urandom(47800));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    cmp({vld, data}, 5'h00);
    for (int i = 0; i < 12; i++) begin
      for (int d = 0; d < 18; d += 2)
        w[d +: 2] = 2'($urandom % 3);
      if (i == 0)
        w[17:10] = 8'hAA;
      k = i % 4 == 2 ? 5 + $urandom % 4 : $urandom % (i[2] ? 9 : 5);
      x = flip(w, k);
      @(posedge clock);
      addr_only <= i[2];
      loc <= w;
      nw <= i % 4 == 3 ? 2'h3 : 2'h2;
      ws <= i % 4 == 0 ? {w, w, w} : i % 4 == 1 ? {x, x, x} :
            i % 4 == 2 ? {w, x, w} : {x, w, w};
      if (!i[2] && (i % 4 == 0 || i % 4 == 3))
        exp_d = dat(w);
      send_n <= 1'b0;
      @(posedge clock);
      send_n <= 1'b1;
      repeat (2) @(posedge clock);
      for (k = 0; busy && k < 9000; k++)
        @(posedge clock);
      if (busy)
        fail_count++;
      #1;
      cmp({vld, data}, {i % 4 == 0, exp_d});
      repeat (300) @(posedge clock);
      #1;
      cmp({vld, data}, {1'b0, exp_d});
    end
    close_out();
  end
endmodule

/* testbench/rad_enc_model.sv */
// Purpose: encoder model driving the serial line
// Assumes: encoder period is ENC clock cycles
// Notes:   line rests low outside words
`timescale 1ns/1ps
module rad_enc_model #(parameter ENC = 20) (
  input  logic        clock,
  input  logic        send_request_n,
  input  logic [53:0] words,
  input  logic [1:0]  n_words,
  output logic        serial_out,
  output logic        busy
);
  task automatic pulse(input logic wide);
    serial_out <= 1'b1;
    repeat (wide ? 3 * ENC : ENC) @(posedge clock);
    serial_out <= 1'b0;
    repeat (wide ? ENC : 3 * ENC) @(posedge clock);
  endtask
  initial begin
    serial_out = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (send_request_n === 1'b0) begin
        busy <= 1'b1;
        for (int w = 0; w < n_words; w++) begin
          for (int d = 18 * w; d < 18 * w + 18; d += 2) begin
            pulse(words[d +: 2] != 2'h0);
            pulse(words[d +: 2] == 2'h1);
          end
          repeat (24 * ENC) @(posedge clock);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
